// *** hdl/scan_pkg.sv ***
// Shared constants and types for the scan and setpoint sequencer.
package scan_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_PS = 25000;
  localparam int ANALOG_MIN_NS = 1000;
  localparam int DIGITAL_MIN_NS = 250;
  localparam int EVAL_DELAY_NS = 2000;
  localparam int STEP_PS = 20830;
  localparam int MAX_PERIOD_HOURS = 19;
  localparam int ANALOG_ENTRY_CYC = (ANALOG_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DIGITAL_ENTRY_CYC =
    (DIGITAL_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int EVAL_CYC = (EVAL_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [63:0] MAX_PERIOD_PS =
    64'(MAX_PERIOD_HOURS) * 64'd3600 * 64'd1000000000000;
  localparam int PERIOD_W = 42;
  localparam int CNT_W = 7;
  // ==========================================================
  // Sizes
  localparam int WORD_W = 16;
  localparam int LIST_DEPTH = 512;
  localparam int LIST_AW = 9;
  localparam int NUM_SP = 16;
  localparam int NUM_TGT = 6;
  localparam int TGT_W = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LW = 5;
  localparam logic [FIFO_LW-1:0] FIFO_ISSUE_LIMIT = 5'h0E;
  localparam int PEND_W = 4;
  // ==========================================================
  // Scan list entry layout
  localparam int LE_W = 12;
  localparam int LE_DIFF_BIT = 0;
  localparam int LE_GAIN_LSB = 1;
  localparam int LE_CHAN_LSB = 4;
  localparam int LE_TYPE_LSB = 10;
  localparam logic [2:0] GAIN_MAX = 3'h6;
  // ==========================================================
  // Setpoint table fields and control layout
  localparam logic [2:0] FLD_CTRL = 3'h0;
  localparam logic [2:0] FLD_ENTRY = 3'h1;
  localparam logic [2:0] FLD_LIM_A = 3'h2;
  localparam logic [2:0] FLD_LIM_B = 3'h3;
  localparam logic [2:0] FLD_VAL_TRUE = 3'h4;
  localparam logic [2:0] FLD_VAL_FALSE = 3'h5;
  localparam int CTRL_W = 8;
  localparam int CTRL_CRIT_LSB = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_TGT_LSB = 4;
  localparam int CTRL_EN_BIT = 7;
  localparam logic [WORD_W-1:0] FLAGS_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] TARGET_RESET = 16'h0000;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ENT_ANALOG = 2'h0, ENT_DIGITAL = 2'h1, ENT_COUNTER = 2'h2,
    ENT_STATUS = 2'h3
  } entry_type_t;
  typedef enum logic [1:0] {
    CRIT_BELOW_A = 2'h0, CRIT_ABOVE_A = 2'h1, CRIT_INSIDE = 2'h2,
    CRIT_OUTSIDE = 2'h3
  } crit_t;
  typedef enum logic [1:0] {
    UPD_TRUE_ONLY = 2'h0, UPD_TRUE_FALSE = 2'h1, UPD_HYSTERESIS = 2'h2,
    UPD_RISING = 2'h3
  } upd_mode_t;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1, SEQ_ISSUE = 4'h2, SEQ_WAIT = 4'h4, SEQ_STATUS = 4'h8
  } seq_state_t;
endpackage

// *** hdl/sp_eval_if.sv ***
// Carrier between the sequencer and one setpoint evaluator.
`timescale 1ns/1ps
interface sp_eval_if;
  import scan_pkg::*;
  logic [WORD_W-1:0] value;
  logic [WORD_W-1:0] lim_a;
  logic [WORD_W-1:0] lim_b;
  logic [WORD_W-1:0] val_true;
  logic [WORD_W-1:0] val_false;
  crit_t crit;
  upd_mode_t mode;
  logic state;
  logic wr_en;
  logic [WORD_W-1:0] wr_val;
  logic new_state;
  modport eval (input value, lim_a, lim_b, val_true, val_false, crit, mode,
                state, output wr_en, wr_val, new_state);
  modport host (output value, lim_a, lim_b, val_true, val_false, crit, mode,
                state, input wr_en, wr_val, new_state);
endinterface

// *** hdl/setpoint_eval.sv ***
// One setpoint: criterion test and output update decision.
`timescale 1ns/1ps
module setpoint_eval (
  sp_eval_if.eval bus
);
  import scan_pkg::*;
  logic crit_true;
  logic in_win;

  // ==========================================================
  // Criterion
  always_comb begin
    in_win = (bus.value < bus.lim_a) && (bus.value > bus.lim_b);
    unique case (bus.crit)
      CRIT_BELOW_A: crit_true = bus.value < bus.lim_a;
      CRIT_ABOVE_A: crit_true = bus.value > bus.lim_a;
      CRIT_INSIDE: crit_true = in_win;
      CRIT_OUTSIDE: crit_true = !in_win;
    endcase
  end

  // ==========================================================
  // Update decision
  always_comb begin
    bus.wr_en = 1'b0;
    bus.wr_val = bus.val_true;
    bus.new_state = crit_true;
    unique case (bus.mode)
      UPD_TRUE_ONLY: bus.wr_en = crit_true;
      UPD_TRUE_FALSE: begin
        bus.wr_en = 1'b1;
        bus.wr_val = crit_true ? bus.val_true : bus.val_false;
      end
      UPD_HYSTERESIS: begin
        // Between the limits the last written side is held.
        bus.new_state = bus.state;
        if (bus.value < bus.lim_b) begin
          bus.wr_en = 1'b1;
          bus.wr_val = bus.val_false;
          bus.new_state = 1'b0;
        end else if (bus.value > bus.lim_a) begin
          bus.wr_en = 1'b1;
          bus.new_state = 1'b1;
        end
      end
      UPD_RISING: bus.wr_en = crit_true && !bus.state;
    endcase
  end
endmodule // setpoint_eval

// *** hdl/word_fifo.sv ***
// Word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input logic clk,
  input logic rst_n,
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // ==========================================================
  // Flags
  assign level = wr_ptr_r - rd_ptr_r;
  assign in_ready = level != (AW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ==========================================================
  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // word_fifo

// *** hdl/scan_setpoint_sequencer.sv ***
// Scan sequencer with setpoint detection and scan data stream.
`timescale 1ns/1ps
module scan_setpoint_sequencer (
  input logic core_clk,
  input logic rst_n,
  input logic acq_enable,
  input logic scan_clk_sel,
  input logic [scan_pkg::PERIOD_W-1:0] scan_period_steps,
  input logic [scan_pkg::LIST_AW-1:0] scan_last,
  input logic ext_scan_clk,
  input logic list_we,
  input logic [scan_pkg::LIST_AW-1:0] list_addr,
  input logic [scan_pkg::LE_W-1:0] list_data,
  input logic sp_we,
  input logic [3:0] sp_sel,
  input logic [2:0] sp_field,
  input logic [scan_pkg::WORD_W-1:0] sp_data,
  input logic sample_valid,
  input logic [scan_pkg::WORD_W-1:0] sample_data,
  output logic conv_start,
  output logic [1:0] conv_type,
  output logic [5:0] conv_chan,
  output logic [2:0] conv_gain,
  output logic conv_diff,
  output logic out_pace,
  output logic [scan_pkg::NUM_TGT-1:0][scan_pkg::WORD_W-1:0] target_value,
  output logic [scan_pkg::NUM_TGT-1:0] target_load,
  output logic [scan_pkg::WORD_W-1:0] setpoint_condition_flags,
  output logic scan_busy,
  output logic scan_overrun,
  output logic stream_valid,
  input logic stream_ready,
  output logic [scan_pkg::WORD_W-1:0] stream_data
);
  import scan_pkg::*;

  // ==========================================================
  // Storage
  logic [LE_W-1:0] list_mem [LIST_DEPTH];
  logic [WORD_W-1:0] samp_mem [LIST_DEPTH];
  logic [LIST_AW-1:0] sp_entry_r [NUM_SP];
  logic [CTRL_W-1:0] sp_ctrl_r [NUM_SP];
  logic [WORD_W-1:0] sp_lima_r [NUM_SP];
  logic [WORD_W-1:0] sp_limb_r [NUM_SP];
  logic [WORD_W-1:0] sp_vt_r [NUM_SP];
  logic [WORD_W-1:0] sp_vf_r [NUM_SP];

  always_ff @(posedge core_clk) begin
    if (list_we) begin
      list_mem[list_addr] <= list_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SP; i++) begin
        sp_entry_r[i] <= '0;
        sp_ctrl_r[i] <= '0;
        sp_lima_r[i] <= '0;
        sp_limb_r[i] <= '0;
        sp_vt_r[i] <= '0;
        sp_vf_r[i] <= '0;
      end
    end else if (sp_we) begin
      case (sp_field)
        FLD_CTRL: sp_ctrl_r[sp_sel] <= sp_data[CTRL_W-1:0];
        FLD_ENTRY: sp_entry_r[sp_sel] <= sp_data[LIST_AW-1:0];
        FLD_LIM_A: sp_lima_r[sp_sel] <= sp_data;
        FLD_LIM_B: sp_limb_r[sp_sel] <= sp_data;
        FLD_VAL_TRUE: sp_vt_r[sp_sel] <= sp_data;
        FLD_VAL_FALSE: sp_vf_r[sp_sel] <= sp_data;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Scan clock sources
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic [63:0] elapsed_ps_r;
  logic [63:0] elapsed_nxt;
  logic [63:0] period_ps;
  logic int_tick;
  logic scan_tick;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_scan_clk;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // The period is kept in picoseconds so the 20.83 ns step never drifts.
  always_comb begin
    period_ps = 64'(scan_period_steps) * 64'(STEP_PS);
    if (period_ps > MAX_PERIOD_PS) begin
      period_ps = MAX_PERIOD_PS;
    end
    if (period_ps < 64'(CLK_PS)) begin
      period_ps = 64'(CLK_PS);
    end
    elapsed_nxt = elapsed_ps_r + 64'(CLK_PS);
    int_tick = elapsed_nxt >= period_ps;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_ps_r <= '0;
    end else if (!acq_enable || scan_clk_sel) begin
      elapsed_ps_r <= '0;
    end else if (int_tick) begin
      elapsed_ps_r <= elapsed_nxt - period_ps;
    end else begin
      elapsed_ps_r <= elapsed_nxt;
    end
  end

  assign scan_tick = acq_enable &&
    (scan_clk_sel ? (ext_s2_r && !ext_s3_r) : int_tick);

  // ==========================================================
  // Sequencer
  seq_state_t state_r;
  logic [LIST_AW-1:0] idx_r;
  logic [LIST_AW-1:0] conv_no_r;
  logic [LIST_AW-1:0] ret_no_r;
  logic [CNT_W-1:0] cnt_r;
  logic [PEND_W-1:0] pend_r;
  logic [LE_W-1:0] cur_entry;
  entry_type_t cur_type;
  logic [2:0] cur_gain;
  logic [FIFO_LW-1:0] fifo_level;
  logic fifo_in_ready;
  logic pipe_idle;
  logic issue;
  logic status_push;
  logic [EVAL_CYC-1:0] dl_valid_r;
  logic [EVAL_CYC-1:0][LIST_AW-1:0] dl_idx_r;
  logic [EVAL_CYC-1:0][LIST_AW-1:0] dl_no_r;
  logic [WORD_W-1:0] flags_r;

  assign cur_entry = list_mem[idx_r];
  assign cur_type = entry_type_t'(cur_entry[LE_TYPE_LSB +: 2]);
  assign cur_gain = cur_entry[LE_GAIN_LSB +: 3];
  assign pipe_idle = (dl_valid_r == '0) && (pend_r == '0);
  // A FIFO holding 14 or more words holds off the next conversion instead of losing words.
  assign issue = (state_r == SEQ_ISSUE) && (cur_type != ENT_STATUS) &&
    (fifo_level < FIFO_ISSUE_LIMIT) && acq_enable;
  // The status word waits for every evaluation of this scan to land.
  assign status_push = (state_r == SEQ_STATUS) && pipe_idle &&
    fifo_in_ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SEQ_IDLE;
      idx_r <= '0;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        SEQ_IDLE: begin
          if (scan_tick) begin
            idx_r <= '0;
            state_r <= SEQ_ISSUE;
          end
        end
        SEQ_ISSUE: begin
          if (!acq_enable) begin
            state_r <= SEQ_IDLE;
          end else if (cur_type == ENT_STATUS) begin
            state_r <= SEQ_STATUS;
          end else if (issue) begin
            cnt_r <= (cur_type == ENT_ANALOG) ?
              CNT_W'(ANALOG_ENTRY_CYC - 2) :
              CNT_W'(DIGITAL_ENTRY_CYC - 2);
            state_r <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (idx_r == scan_last || !acq_enable) begin
            state_r <= SEQ_IDLE;
          end else begin
            idx_r <= idx_r + 1'b1;
            state_r <= SEQ_ISSUE;
          end
        end
        SEQ_STATUS: begin
          if (status_push) begin
            if (idx_r == scan_last || !acq_enable) begin
              state_r <= SEQ_IDLE;
            end else begin
              idx_r <= idx_r + 1'b1;
              state_r <= SEQ_ISSUE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
      conv_type <= '0;
      conv_chan <= '0;
      conv_gain <= '0;
      conv_diff <= 1'b0;
      out_pace <= 1'b0;
      scan_busy <= 1'b0;
    end else begin
      conv_start <= issue;
      out_pace <= scan_tick;
      scan_busy <= state_r != SEQ_IDLE;
      if (issue) begin
        conv_type <= cur_type;
        conv_chan <= cur_entry[LE_CHAN_LSB +: 6];
        conv_gain <= (cur_gain > GAIN_MAX) ? GAIN_MAX : cur_gain;
        conv_diff <= cur_entry[LE_DIFF_BIT];
      end
    end
  end

  // ==========================================================
  // Sample return and evaluation delay
  always_ff @(posedge core_clk) begin
    if (sample_valid) begin
      samp_mem[ret_no_r] <= sample_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_no_r <= '0;
      ret_no_r <= '0;
      pend_r <= '0;
      dl_valid_r <= '0;
      dl_idx_r <= '0;
      dl_no_r <= '0;
    end else begin
      conv_no_r <= conv_no_r + LIST_AW'(issue);
      ret_no_r <= ret_no_r + LIST_AW'(sample_valid);
      pend_r <= pend_r + PEND_W'(issue) - PEND_W'(sample_valid);
      dl_valid_r <= {dl_valid_r[EVAL_CYC-2:0], issue};
      dl_idx_r <= {dl_idx_r[EVAL_CYC-2:0], idx_r};
      dl_no_r <= {dl_no_r[EVAL_CYC-2:0], conv_no_r};
    end
  end

  // ==========================================================
  // Setpoints
  sp_eval_if ev [NUM_SP] ();
  logic [NUM_SP-1:0] sp_match;
  logic [NUM_SP-1:0] sp_wr;
  logic [NUM_SP-1:0] sp_new;
  logic [WORD_W-1:0] sp_val [NUM_SP];
  logic [TGT_W-1:0] sp_tgt [NUM_SP];
  logic eval_fire;
  logic [LIST_AW-1:0] eval_idx;
  logic [WORD_W-1:0] eval_value;

  assign eval_fire = dl_valid_r[EVAL_CYC-1];
  assign eval_idx = dl_idx_r[EVAL_CYC-1];
  assign eval_value = samp_mem[dl_no_r[EVAL_CYC-1]];

  generate
    for (genvar g = 0; g < NUM_SP; g++) begin : g_sp
      assign ev[g].value = eval_value;
      assign ev[g].lim_a = sp_lima_r[g];
      assign ev[g].lim_b = sp_limb_r[g];
      assign ev[g].val_true = sp_vt_r[g];
      assign ev[g].val_false = sp_vf_r[g];
      assign ev[g].crit = crit_t'(sp_ctrl_r[g][CTRL_CRIT_LSB +: 2]);
      assign ev[g].mode = upd_mode_t'(sp_ctrl_r[g][CTRL_MODE_LSB +: 2]);
      assign ev[g].state = flags_r[g];
      assign sp_match[g] = eval_fire && sp_ctrl_r[g][CTRL_EN_BIT] &&
        (sp_entry_r[g] == eval_idx);
      assign sp_wr[g] = ev[g].wr_en;
      assign sp_new[g] = ev[g].new_state;
      assign sp_val[g] = ev[g].wr_val;
      assign sp_tgt[g] = sp_ctrl_r[g][CTRL_TGT_LSB +: TGT_W];
      setpoint_eval u_eval (
        .bus(ev[g])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= FLAGS_RESET;
    end else begin
      for (int i = 0; i < NUM_SP; i++) begin
        if (sp_match[i]) begin
          flags_r[i] <= sp_new[i];
        end
      end
    end
  end

  // ==========================================================
  // Output targets
  logic [NUM_TGT-1:0][WORD_W-1:0] tgt_nxt;
  logic [NUM_TGT-1:0] load_nxt;

  // Higher setpoint numbers are looked at later and so win a tie.
  always_comb begin
    tgt_nxt = target_value;
    load_nxt = '0;
    for (int t = 0; t < NUM_TGT; t++) begin
      for (int i = 0; i < NUM_SP; i++) begin
        if (sp_match[i] && sp_wr[i] && sp_tgt[i] == TGT_W'(t)) begin
          tgt_nxt[t] = sp_val[i];
          load_nxt[t] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      target_value <= {NUM_TGT{TARGET_RESET}};
      target_load <= '0;
      setpoint_condition_flags <= FLAGS_RESET;
    end else begin
      target_value <= tgt_nxt;
      target_load <= load_nxt;
      setpoint_condition_flags <= flags_r;
    end
  end

  // ==========================================================
  // Stream buffer and overrun
  logic fifo_in_valid;
  logic [WORD_W-1:0] fifo_in_data;
  logic overrun_set;

  assign fifo_in_valid = sample_valid || status_push;
  assign fifo_in_data = status_push ? flags_r : sample_data;
  assign overrun_set = (scan_tick && state_r != SEQ_IDLE) ||
    (sample_valid && !fifo_in_ready);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_overrun <= 1'b0;
    end else if (overrun_set) begin
      scan_overrun <= 1'b1;
    end else if (!acq_enable) begin
      scan_overrun <= 1'b0;
    end
  end

  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(stream_valid),
    .out_ready(stream_ready),
    .out_data(stream_data),
    .level(fifo_level)
  );
endmodule // scan_setpoint_sequencer

// *** test/scan_setpoint_sequencer_properties.sv ***
// Port-level assertions for the scan and setpoint sequencer.
`timescale 1ns/1ps
module scan_setpoint_sequencer_properties (
  input logic core_clk,
  input logic rst_n,
  input logic scan_clk_sel,
  input logic ext_scan_clk,
  input logic conv_start,
  input logic [2:0] conv_gain,
  input logic out_pace,
  input logic [scan_pkg::NUM_TGT-1:0][scan_pkg::WORD_W-1:0] target_value,
  input logic [scan_pkg::NUM_TGT-1:0] target_load,
  input logic [scan_pkg::WORD_W-1:0] setpoint_condition_flags,
  input logic scan_busy,
  input logic stream_valid,
  input logic stream_ready,
  input logic [scan_pkg::WORD_W-1:0] stream_data
);
  import scan_pkg::*;
  default clocking dck @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ====================
  // Assertions
  ext_pace_a: assert property (
    $rose(ext_scan_clk) && scan_clk_sel |-> ##[3:4] out_pace)
    else $error("scan pace late after external edge");
  scan_start_a: assert property (
    $rose(scan_busy) |-> ##[0:1] conv_start)
    else $error("scan began without a conversion");
  gain_range_a: assert property (
    conv_start |-> conv_gain <= 3'h6)
    else $error("gain outside the seven ranges");
  eval_delay_a: assert property (
    |target_load |-> $past(conv_start, 80))
    else $error("output update not two microseconds after conversion");
  flags_refresh_a: assert property (
    $changed(setpoint_condition_flags) |-> $past(conv_start, 81))
    else $error("status flags changed outside an evaluation");
  target_hold_a: assert property (
    $changed(target_value) |-> |target_load)
    else $error("target changed without a load");
  entry_spacing_a: assert property (
    conv_start |=> !conv_start [*8])
    else $error("conversions closer than the slot");
  stream_hold_a: assert property (
    stream_valid && !stream_ready |=> stream_valid && $stable(stream_data))
    else $error("stream word dropped while stalled");
endmodule // scan_setpoint_sequencer_properties

bind scan_setpoint_sequencer scan_setpoint_sequencer_properties i_props (
  .core_clk(core_clk), .rst_n(rst_n), .scan_clk_sel(scan_clk_sel),
  .ext_scan_clk(ext_scan_clk), .conv_start(conv_start),
  .conv_gain(conv_gain), .out_pace(out_pace), .target_value(target_value),
  .target_load(target_load), .scan_busy(scan_busy),
  .setpoint_condition_flags(setpoint_condition_flags),
  .stream_valid(stream_valid), .stream_ready(stream_ready),
  .stream_data(stream_data));

// *** test/stream_host.sv ***
// Host model that takes the scan stream and can hold it off.
`timescale 1ns/1ps
module stream_host (
  input logic core_clk,
  input logic rst_n,
  input logic hold,
  input logic stream_valid,
  output logic stream_ready,
  input logic [15:0] stream_data
);
  logic [15:0] got [$];
  // Ready is low in reset so no word is taken before the stream is defined.
  assign stream_ready = rst_n && !hold;
  always @(posedge core_clk) begin
    if (stream_valid === 1'b1 && stream_ready) begin
      got.push_back(stream_data);
    end
  end
endmodule // stream_host

// *** test/test_scan_setpoint_sequencer.sv ***
// Self-checking bench for the scan and setpoint sequencer.
`timescale 1ns/1ps
module test_scan_setpoint_sequencer;
  import scan_pkg::*;
  typedef struct {logic [15:0] v0, v1, flags, t0, t3, t4;} row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic acq_enable = 1'b0;
  logic scan_clk_sel = 1'b1;
  logic ext_scan_clk = 1'b0;
  logic [PERIOD_W-1:0] scan_period_steps = 42'h9C4;
  logic [LIST_AW-1:0] scan_last = 9'h002;
  logic [LIST_AW-1:0] list_addr = 9'h000;
  logic [LE_W-1:0] list_data = 12'h000;
  logic list_we = 1'b0;
  logic sp_we = 1'b0;
  logic sample_valid = 1'b0;
  logic hold = 1'b0;
  logic [3:0] sp_sel = 4'h0;
  logic [2:0] sp_field = 3'h0;
  logic [WORD_W-1:0] sp_data = 16'h0000;
  logic [WORD_W-1:0] sample_data = 16'h0000;
  logic conv_start, conv_diff, out_pace, scan_busy, scan_overrun;
  logic stream_valid, stream_ready;
  logic [1:0] conv_type;
  logic [5:0] conv_chan;
  logic [2:0] conv_gain;
  logic [NUM_TGT-1:0][WORD_W-1:0] target_value;
  logic [NUM_TGT-1:0] target_load;
  logic [WORD_W-1:0] setpoint_condition_flags, stream_data, gexp;
  logic [WORD_W-1:0] smp [64];
  logic [11:0] lst [3] = '{12'h457, 12'h07E, 12'hC00};
  row_t rows [5];
  row_t x;
  int k;
  int n_errors = 0;
  int comparisons = 0;

  scan_setpoint_sequencer i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .acq_enable(acq_enable), .scan_clk_sel(scan_clk_sel),
    .scan_period_steps(scan_period_steps), .scan_last(scan_last),
    .ext_scan_clk(ext_scan_clk), .list_we(list_we), .list_addr(list_addr),
    .list_data(list_data), .sp_we(sp_we), .sp_sel(sp_sel),
    .sp_field(sp_field), .sp_data(sp_data), .sample_valid(sample_valid),
    .sample_data(sample_data), .conv_start(conv_start),
    .conv_type(conv_type), .conv_chan(conv_chan), .conv_gain(conv_gain),
    .conv_diff(conv_diff), .out_pace(out_pace),
    .target_value(target_value), .target_load(target_load),
    .setpoint_condition_flags(setpoint_condition_flags),
    .scan_busy(scan_busy), .scan_overrun(scan_overrun),
    .stream_valid(stream_valid), .stream_ready(stream_ready),
    .stream_data(stream_data));
  stream_host i_host (.core_clk(core_clk), .rst_n(rst_n), .hold(hold),
    .stream_valid(stream_valid), .stream_ready(stream_ready),
    .stream_data(stream_data));

  initial forever #12.5 core_clk = ~core_clk;

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (8) @(posedge core_clk);
    while (scan_busy !== 1'b0) begin
      @(posedge core_clk);
      n++;
      if (n > 2000) begin
        n_errors++;
        tally_and_finish();
      end
    end
    repeat (8) @(posedge core_clk);
  endtask

  task automatic wait_pace(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (out_pace !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  // Callers lower the write strobe once, after the last call.
  task automatic sp_write(logic [3:0] s, logic [15:0] c, e, a, b, t, f);
    logic [15:0] w [6];
    w = '{c, e, a, b, t, f};
    for (int i = 0; i < 6; i++) begin
      sp_we <= 1'b1;
      sp_sel <= s;
      sp_field <= 3'(i);
      sp_data <= w[i];
      @(posedge core_clk);
    end
  endtask

  // ====================
  // Converter stand-in: one result per conversion, on the next edge
  always @(posedge core_clk) begin
    sample_valid <= 1'b0;
    if (conv_start === 1'b1 && conv_type !== 2'h3) begin
      sample_valid <= 1'b1;
      sample_data <= smp[conv_chan];
      gexp = (conv_chan == 6'h07) ? 16'h0006 : 16'h000B;
      check("gain", 16'({conv_diff, conv_gain}), gexp);
    end
  end

  // ====================
  // Main sequence
  initial begin
    rows = '{
      '{16'h0500, 16'h0600, 16'h0003, 16'h0030, 16'h0B0B, 16'h0000},
      '{16'h0150, 16'h2000, 16'h8011, 16'h0070, 16'h0A0A, 16'h00AA},
      '{16'h0050, 16'h2000, 16'h8010, 16'h0070, 16'h0A0A, 16'h00AA},
      '{16'h0100, 16'h1000, 16'h8010, 16'h0070, 16'h0A0A, 16'h00AA},
      '{16'h0500, 16'h0050, 16'h0001, 16'h0030, 16'h0A0A, 16'h0055}};
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check("reset flags", setpoint_condition_flags, FLAGS_RESET);
    check("reset target", target_value[3], TARGET_RESET);
    $display("reset done");
    for (int i = 0; i < 3; i++) begin
      list_we <= 1'b1;
      list_addr <= 9'(i);
      list_data <= lst[i];
      @(posedge core_clk);
    end
    list_we <= 1'b0;
    sp_write(4'h0, 16'h00B2, 16'h0000, 16'h1000, 16'h0100, 16'h0A0A, 16'h0C0C);
    sp_write(4'h1, 16'h00BE, 16'h0001, 16'h1000, 16'h0100, 16'h0B0B, 16'h0D0D);
    sp_write(4'h4, 16'h0084, 16'h0000, 16'h0200, 16'h0000, 16'h0070, 16'h0030);
    sp_write(4'hF, 16'h00C8, 16'h0001, 16'h1000, 16'h0100, 16'h00AA, 16'h0055);
    sp_we <= 1'b0;
    acq_enable <= 1'b1;
    @(posedge core_clk);
    for (int r = 0; r < 5; r++) begin
      x = rows[r];
      smp[5] = x.v0;
      smp[7] = x.v1;
      hold <= (r == 2);
      ext_scan_clk <= 1'b1;
      repeat (3) @(posedge core_clk);
      ext_scan_clk <= 1'b0;
      wait_idle();
      if (r == 2) begin
        check("held valid", 16'(stream_valid), 16'h0001);
        check("held count", 16'(i_host.got.size()), 16'h0000);
        hold <= 1'b0;
        repeat (8) @(posedge core_clk);
      end
      check("flags", setpoint_condition_flags, x.flags);
      check("port", target_value[0], x.t0);
      check("aout", target_value[3], x.t3);
      check("timer", target_value[4], x.t4);
      check("count", 16'(i_host.got.size()), 16'h0003);
      check("word0", i_host.got.pop_front(), x.v0);
      check("word1", i_host.got.pop_front(), x.v1);
      check("status", i_host.got.pop_front(), x.flags);
      $display("row %0d done", r);
    end
    // A second external edge inside a running scan must flag an overrun.
    check("no overrun", 16'(scan_overrun), 16'h0000);
    for (int p = 0; p < 2; p++) begin
      ext_scan_clk <= 1'b1;
      repeat (3) @(posedge core_clk);
      ext_scan_clk <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    wait_idle();
    check("overrun", 16'(scan_overrun), 16'h0001);
    $display("overrun done");
    // 2500 steps is an exact number of clocks, so every interval is equal.
    scan_clk_sel <= 1'b0;
    wait_pace(k);
    wait_pace(k);
    check("period", 16'(k), 16'h0823);
    acq_enable <= 1'b0;
    wait_idle();
    check("overrun clear", 16'(scan_overrun), 16'h0000);
    $display("internal timer done");
    tally_and_finish();
  end
endmodule // test_scan_setpoint_sequencer
